// ==== rtl/serial_pkg.sv ====
// constants and types of the serial block
package serial_pkg;
   localparam int DATA_W    = 16;
   localparam int DEPTH     = 8;
   localparam int PTR_W     = 3;
   localparam int CNT_W     = 4;
   localparam int BUF_AW    = 8;
   localparam int BUF_WORDS = 256;
   localparam int REG_W     = 32;
   localparam logic [3:0] OVS_RST   = 4'h7;
   localparam logic [3:0] WIDTH_RST = 4'h7;

   typedef enum logic [1:0] {
      PROTO_TWO_WIRE = 2'h0,
      PROTO_SERIAL   = 2'h1,
      PROTO_ASYNC    = 2'h2
   } proto_t;
   typedef enum logic [1:0] {
      FRAME_PHASE      = 2'h0,
      FRAME_SYNC_PULSE = 2'h1,
      FRAME_HALF_DUPLX = 2'h2
   } frame_t;
   typedef enum logic [1:0] {
      MEM_QUEUE     = 2'h0,
      MEM_ADDRESSED = 2'h1,
      MEM_COMMAND_RESPONSE_MODE  = 2'h2
   } bufmode_t;
   typedef enum logic [2:0] {
      MST_IDLE  = 3'h1,
      MST_SHIFT = 3'h2,
      MST_DONE  = 3'h4
   } mst_t;

   typedef struct packed {
      logic [21:0] rsvd;
      logic        enable;
      proto_t      proto;
      logic        ext_clocked;
      bufmode_t    bufmode;
      logic [3:0]  ovs;
   } top_ctrl_t;
   typedef struct packed {
      logic [25:0] rsvd;
      logic        master;
      frame_t      framing;
      logic [1:0]  submode;
      logic        sel_type;
   } proto_ctrl_t;
   typedef struct packed {
      logic [25:0] rsvd;
      logic [3:0]  width;
      logic        msb_first;
      logic        median;
   } fmt_t;
   typedef struct packed {
      logic [26:0] rsvd;
      logic [2:0]  trigger;
      logic        clear;
      logic        freeze;
   } qctl_t;
   typedef struct packed {
      logic [19:0]      rsvd;
      logic [CNT_W-1:0] count;
      logic [PTR_W-1:0] rd_ptr;
      logic [PTR_W-1:0] wr_ptr;
      logic             valid;
      logic             trig_hit;
   } qstat_t;
   typedef struct packed {
      logic [22:0]       rsvd;
      logic              busy;
      logic [BUF_AW-1:0] addr;
   } pstat_t;
   typedef struct packed {
      logic [30:0] rsvd;
      logic        ext_using;
   } tstat_t;

   // width fields hold frame length minus one
   function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [3:0] width,
                                           input logic msb);
      bit_pos = msb ? 4'(width - idx) : idx;
   endfunction : bit_pos
endpackage : serial_pkg

// ==== rtl/queue_if.sv ====
// carrier to one frame queue
`timescale 1ns/1ps
interface queue_if;
   import serial_pkg::*;
   logic              push;
   logic              pop;
   logic              clear;
   logic              freeze;
   logic [DATA_W-1:0] push_data;
   logic [DATA_W-1:0] head;
   logic [CNT_W-1:0]  count;
   logic [PTR_W-1:0]  rd_ptr;
   logic [PTR_W-1:0]  wr_ptr;
   modport owner (output push, pop, clear, freeze, push_data,
                  input head, count, rd_ptr, wr_ptr);
   modport store (input push, pop, clear, freeze, push_data,
                  output head, count, rd_ptr, wr_ptr);
endinterface : queue_if

// ==== rtl/serial_queue.sv ====
// frame queue with clear and freeze
`timescale 1ns/1ps
module serial_queue import serial_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   queue_if.store   q
);
   logic [DATA_W-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0]  rd_ff;
   logic [PTR_W-1:0]  wr_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic              do_push;
   logic              do_pop;

   // freeze holds contents and pointers unless clear is also set
   assign do_push = q.push && !q.freeze && (cnt_ff != CNT_W'(DEPTH));
   assign do_pop  = q.pop && !q.freeze && (cnt_ff != '0);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_ff  <= '0;
         wr_ff  <= '0;
         cnt_ff <= '0;
      end else if (q.clear) begin
         rd_ff  <= '0;
         wr_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ff <= rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + CNT_W'(do_push) - CNT_W'(do_pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (do_push && !q.clear) begin
         mem_ff[wr_ff] <= q.push_data;
      end
   end

   // empty queue shows zero, not stale data
   assign q.head   = (cnt_ff == '0) ? '0 : mem_ff[rd_ff];
   assign q.count  = cnt_ff;
   assign q.rd_ptr = rd_ff;
   assign q.wr_ptr = wr_ff;
endmodule : serial_queue

// ==== rtl/serial_block.sv ====
// four-wire serial block: setup, enable, pads and queues
// Summary of operation
// - queue setup: trigger levels, then empty queues and shifters
// - serial operation starts only once enable is one
// - top, protocol and format control changes take effect only at the next enable; queue control acts at once
// - each enable reinitialises state and empties queues
// - master drives clock, select, data out with enables; data in is input
// - slave takes clock, select, data in; drives data out with enable
// - a push places one frame in the transmit queue
// - a pop read returns the oldest receive frame and removes it
// - a peek read returns the oldest receive frame and keeps it
// - each queue reports count, both pointers, valid data
// - queue control gives trigger level, clear and freeze
// - status shows link side may be using the buffer memory
// - protocol status shows bus busy and the slave buffer address
// - protocol control picks role, framing, clock submode, select type
// - receive format: width, bit order, median filter
// - every control and status register is 32 bits wide
// - top control: enable, protocol, clocking, buffer mode
// - a data port reaches one buffer memory location
`timescale 1ns/1ps
module serial_block import serial_pkg::*; (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire top_ctrl_t         block_top_control,
   input  wire proto_ctrl_t       serial_protocol_control,
   input  wire fmt_t              transmit_format_control,
   input  wire fmt_t              receive_format_control,
   input  wire qctl_t             transmit_queue_control,
   input  wire qctl_t             receive_queue_control,
   input  wire logic              push_strobe,
   input  wire logic [REG_W-1:0]  transmit_queue_push,
   input  wire logic              pop_strobe,
   input  wire logic [BUF_AW-1:0] buf_sw_addr,
   input  wire logic              buf_sw_wr,
   input  wire logic [7:0]        buf_sw_wdata,
   input  wire logic              spi_clk_in,
   input  wire logic              spi_select_in,
   input  wire logic              spi_mosi_in,
   input  wire logic              spi_miso_in,
   output logic                   spi_clk_out,
   output logic                   spi_clk_out_en,
   output logic                   spi_select_out,
   output logic                   spi_select_out_en,
   output logic                   spi_mosi_out,
   output logic                   spi_mosi_out_en,
   output logic                   spi_miso_out,
   output logic                   spi_miso_out_en,
   output qstat_t                 transmit_queue_state,
   output qstat_t                 receive_queue_state,
   output pstat_t                 serial_protocol_status,
   output tstat_t                 block_top_status,
   output logic [REG_W-1:0]       receive_queue_pop,
   output logic [REG_W-1:0]       receive_queue_peek,
   output logic [REG_W-1:0]       buffer_memory_word
);
   queue_if txq ();
   queue_if rxq ();

   serial_queue u_txq (
      .mclk (mclk),
      .rst  (rst),
      .q    (txq.store)
   );
   serial_queue u_rxq (
      .mclk (mclk),
      .rst  (rst),
      .q    (rxq.store)
   );

   top_ctrl_t         top_ff;
   proto_ctrl_t       proto_ff;
   fmt_t              txf_ff;
   fmt_t              rxf_ff;
   logic              en_d_ff;
   logic              run_ff;
   logic              slv_run_ff;
   logic              en_rise;
   logic              master;
   logic              cpol;
   logic              cpha;
   logic              buffered;
   mst_t              st_ff;
   logic [3:0]        div_ff;
   logic [3:0]        bit_ff;
   logic              sclk_lvl_ff;
   logic [DATA_W-1:0] mw_ff;
   logic [DATA_W-1:0] mr_ff;
   logic              mosi_ff;
   logic              lead;
   logic              trail;
   logic              mst_take;
   logic              mi_s1_ff;
   logic              mi_s2_ff;
   logic              mi_h1_ff;
   logic              mi_h2_ff;
   logic              miso_f;
   logic              lk_rst;
   logic [3:0]        lk_cnt_ff;
   logic [DATA_W-1:0] lk_sh_ff;
   logic [DATA_W-1:0] lk_word_ff;
   logic [DATA_W-1:0] lk_txw_ff;
   logic              lk_tgl_ff;
   logic              lk_ack_ff;
   logic              lk_req_s1_ff;
   logic              lk_req_s2_ff;
   logic [DATA_W-1:0] nxt_lk_sh;
   logic              lk_last;
   logic              tg_s1_ff;
   logic              tg_s2_ff;
   logic              tg_s3_ff;
   logic              ak_s1_ff;
   logic              ak_s2_ff;
   logic              se_s1_ff;
   logic              se_s2_ff;
   logic              se_s3_ff;
   logic              req_ff;
   logic [DATA_W-1:0] hold_ff;
   logic              slv_evt;
   logic              slv_take;
   logic              first_ff;
   logic [BUF_AW-1:0] addr_ff;
   logic              ext_wr;
   logic [7:0]        bmem [BUF_WORDS];

   function automatic qstat_t make_qstat(input logic [CNT_W-1:0] cnt,
                                         input logic [PTR_W-1:0] rp,
                                         input logic [PTR_W-1:0] wp,
                                         input logic hit);
      make_qstat          = '0;
      make_qstat.count    = cnt;
      make_qstat.rd_ptr   = rp;
      make_qstat.wr_ptr   = wp;
      make_qstat.valid    = (cnt != '0);
      make_qstat.trig_hit = hit;
   endfunction : make_qstat

   // configuration is sampled only on the enable edge
   assign en_rise  = block_top_control.enable && !en_d_ff;
   assign master   = proto_ff.master;
   assign cpol     = proto_ff.submode[1];
   assign cpha     = proto_ff.submode[0];
   assign buffered = (top_ff.bufmode != MEM_QUEUE) && !master;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         top_ff   <= '0;
         proto_ff <= '0;
         txf_ff   <= '0;
         rxf_ff   <= '0;
      end else if (en_rise) begin
         top_ff   <= block_top_control;
         proto_ff <= serial_protocol_control;
         txf_ff   <= transmit_format_control;
         rxf_ff   <= receive_format_control;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         en_d_ff    <= 1'b0;
         run_ff     <= 1'b0;
         slv_run_ff <= 1'b0;
      end else begin
         en_d_ff    <= block_top_control.enable;
         run_ff     <= block_top_control.enable && ((en_rise ? block_top_control.proto :
                       top_ff.proto) == PROTO_SERIAL);
         slv_run_ff <= run_ff && !master;
      end
   end

   // enable edge empties both queues like a clear
   assign txq.clear     = transmit_queue_control.clear | en_rise;
   assign txq.freeze    = transmit_queue_control.freeze;
   assign txq.push      = push_strobe;
   assign txq.push_data = transmit_queue_push[DATA_W-1:0];
   assign txq.pop       = mst_take | slv_take;
   assign rxq.clear     = receive_queue_control.clear | en_rise;
   assign rxq.freeze    = receive_queue_control.freeze;
   assign rxq.pop       = pop_strobe;
   assign rxq.push      = (st_ff == MST_DONE) || (slv_evt && !buffered);
   assign rxq.push_data = master ? mr_ff : lk_word_ff;

   // master clock: ovs+1 cycles per bit
   assign lead     = (div_ff == (top_ff.ovs >> 1));
   assign trail    = (div_ff == top_ff.ovs);
   assign mst_take = (st_ff == MST_IDLE) && run_ff && master &&
                     (txq.count != '0) && !txq.freeze;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff       <= MST_IDLE;
         div_ff      <= '0;
         bit_ff      <= '0;
         sclk_lvl_ff <= 1'b0;
      end else if (!run_ff || txq.clear) begin
         st_ff       <= MST_IDLE;
         div_ff      <= '0;
         bit_ff      <= '0;
         sclk_lvl_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            MST_IDLE: begin
               div_ff <= '0;
               bit_ff <= '0;
               if (mst_take) begin
                  st_ff <= MST_SHIFT;
               end
            end
            MST_SHIFT: begin
               div_ff <= trail ? 4'h0 : 4'(div_ff + 1'b1);
               if (lead) begin
                  sclk_lvl_ff <= 1'b1;
               end
               if (trail) begin
                  sclk_lvl_ff <= 1'b0;
                  if (bit_ff == txf_ff.width) begin
                     st_ff <= MST_DONE;
                  end else begin
                     bit_ff <= bit_ff + 1'b1;
                  end
               end
            end
            MST_DONE: st_ff <= MST_IDLE;
            default:  st_ff <= MST_IDLE;
         endcase
      end
   end

   // submode picks launch and capture edges
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mw_ff   <= '0;
         mr_ff   <= '0;
         mosi_ff <= 1'b0;
      end else begin
         if (mst_take) begin
            mw_ff   <= txq.head;
            mosi_ff <= txq.head[bit_pos(4'h0, txf_ff.width, txf_ff.msb_first)];
         end
         if (st_ff == MST_SHIFT) begin
            if (lead && cpha) begin
               mosi_ff <= mw_ff[bit_pos(bit_ff, txf_ff.width, txf_ff.msb_first)];
            end
            if (lead && !cpha) begin
               mr_ff[bit_pos(bit_ff, rxf_ff.width, rxf_ff.msb_first)] <= miso_f;
            end
            if (trail && cpha) begin
               mr_ff[bit_pos(bit_ff, rxf_ff.width, rxf_ff.msb_first)] <= miso_f;
            end
            if (trail && !cpha && (bit_ff != txf_ff.width)) begin
               mosi_ff <= mw_ff[bit_pos(4'(bit_ff + 1'b1), txf_ff.width,
                                        txf_ff.msb_first)];
            end
         end
         if (mst_take || rxq.clear) begin
            mr_ff <= '0;
         end
      end
   end

   // data in: two flops, then optional majority of three
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mi_s1_ff <= 1'b0;
         mi_s2_ff <= 1'b0;
         mi_h1_ff <= 1'b0;
         mi_h2_ff <= 1'b0;
      end else begin
         mi_s1_ff <= spi_miso_in;
         mi_s2_ff <= mi_s1_ff;
         mi_h1_ff <= mi_s2_ff;
         mi_h2_ff <= mi_h1_ff;
      end
   end
   assign miso_f = rxf_ff.median ? ((mi_s2_ff & mi_h1_ff) | (mi_s2_ff & mi_h2_ff) |
                                    (mi_h1_ff & mi_h2_ff)) : mi_s2_ff;

   // slave shifts on the pin clock; deselect ends the frame
   assign lk_rst  = rst | spi_select_in | !slv_run_ff;
   assign lk_last = (lk_cnt_ff == txf_ff.width);

   always_comb begin
      nxt_lk_sh = lk_sh_ff;
      nxt_lk_sh[bit_pos(lk_cnt_ff, rxf_ff.width, rxf_ff.msb_first)] = spi_mosi_in;
   end

   always_ff @(posedge spi_clk_in or posedge lk_rst) begin
      if (lk_rst) begin
         lk_cnt_ff <= '0;
         lk_sh_ff  <= '0;
      end else begin
         lk_cnt_ff <= lk_last ? 4'h0 : 4'(lk_cnt_ff + 1'b1);
         lk_sh_ff  <= lk_last ? '0 : nxt_lk_sh;
      end
   end

   // toggles survive deselect so the crossing keeps its parity
   always_ff @(posedge spi_clk_in or posedge rst) begin
      if (rst) begin
         lk_word_ff   <= '0;
         lk_txw_ff    <= '1;
         lk_tgl_ff    <= 1'b0;
         lk_ack_ff    <= 1'b0;
         lk_req_s1_ff <= 1'b0;
         lk_req_s2_ff <= 1'b0;
      end else begin
         lk_req_s1_ff <= req_ff;
         lk_req_s2_ff <= lk_req_s1_ff;
         if (lk_last && slv_run_ff && !spi_select_in) begin
            lk_word_ff <= nxt_lk_sh;
            lk_tgl_ff  <= !lk_tgl_ff;
            if (lk_req_s2_ff != lk_ack_ff) begin
               lk_txw_ff <= hold_ff;
               lk_ack_ff <= lk_req_s2_ff;
            end else begin
               lk_txw_ff <= '1;
            end
         end
      end
   end

   // outgoing bit changes on the falling pin clock edge
   always_ff @(negedge spi_clk_in or posedge lk_rst) begin
      if (lk_rst) begin
         spi_miso_out <= 1'b1;
      end else begin
         spi_miso_out <= lk_txw_ff[bit_pos(lk_cnt_ff, txf_ff.width, txf_ff.msb_first)];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tg_s1_ff <= 1'b0;
         tg_s2_ff <= 1'b0;
         tg_s3_ff <= 1'b0;
         ak_s1_ff <= 1'b0;
         ak_s2_ff <= 1'b0;
         se_s1_ff <= 1'b1;
         se_s2_ff <= 1'b1;
         se_s3_ff <= 1'b1;
      end else begin
         tg_s1_ff <= lk_tgl_ff;
         tg_s2_ff <= tg_s1_ff;
         tg_s3_ff <= tg_s2_ff;
         ak_s1_ff <= lk_ack_ff;
         ak_s2_ff <= ak_s1_ff;
         se_s1_ff <= spi_select_in;
         se_s2_ff <= se_s1_ff;
         se_s3_ff <= se_s2_ff;
      end
   end

   assign slv_evt  = (tg_s2_ff ^ tg_s3_ff) && slv_run_ff;
   assign slv_take = slv_run_ff && !buffered && (req_ff == ak_s2_ff) &&
                     (txq.count != '0) && !txq.freeze;

   // hold word stays until the pin side acknowledges
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_ff  <= 1'b0;
         hold_ff <= '1;
      end else if (slv_run_ff && (req_ff == ak_s2_ff)) begin
         if (buffered) begin
            hold_ff <= DATA_W'(bmem[addr_ff]);
            req_ff  <= !req_ff;
         end else if (slv_take) begin
            hold_ff <= txq.head;
            req_ff  <= !req_ff;
         end
      end
   end

   // first buffered byte is the address, then data
   assign ext_wr = slv_evt && buffered && !first_ff;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         first_ff <= 1'b1;
         addr_ff  <= '0;
      end else if (!se_s2_ff && se_s3_ff) begin
         first_ff <= 1'b1;
      end else if (slv_evt && buffered) begin
         if (first_ff) begin
            addr_ff  <= lk_word_ff[BUF_AW-1:0];
            first_ff <= 1'b0;
         end else begin
            addr_ff  <= addr_ff + 1'b1;
         end
      end
   end

   // link-side write wins; a clashing software write is dropped
   always_ff @(posedge mclk) begin
      if (ext_wr) begin
         bmem[addr_ff] <= lk_word_ff[7:0];
      end else if (buf_sw_wr) begin
         bmem[buf_sw_addr] <= buf_sw_wdata;
      end
   end

   // master drives three pads, slave only its data out
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         spi_clk_out       <= 1'b0;
         spi_clk_out_en    <= 1'b0;
         spi_select_out    <= 1'b1;
         spi_select_out_en <= 1'b0;
         spi_mosi_out      <= 1'b0;
         spi_mosi_out_en   <= 1'b0;
         spi_miso_out_en   <= 1'b0;
      end else begin
         spi_clk_out       <= cpol ^ sclk_lvl_ff;
         spi_clk_out_en    <= run_ff && master;
         spi_select_out_en <= run_ff && master;
         spi_mosi_out_en   <= run_ff && master;
         spi_mosi_out      <= mosi_ff;
         spi_miso_out_en   <= slv_run_ff && !se_s2_ff;
         if (proto_ff.framing == FRAME_SYNC_PULSE) begin
            spi_select_out <= (st_ff == MST_SHIFT) &&
                              (bit_ff == (proto_ff.sel_type ? txf_ff.width : 4'h0));
         end else begin
            spi_select_out <= (st_ff != MST_SHIFT);
         end
      end
   end

   // status words, upper bits zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         transmit_queue_state   <= '0;
         receive_queue_state    <= '0;
         serial_protocol_status <= '0;
         block_top_status       <= '0;
         receive_queue_pop      <= '0;
         receive_queue_peek     <= '0;
         buffer_memory_word     <= '0;
      end else begin
         transmit_queue_state <= make_qstat(txq.count, txq.rd_ptr, txq.wr_ptr,
                                            txq.count <= CNT_W'(transmit_queue_control.trigger));
         receive_queue_state  <= make_qstat(rxq.count, rxq.rd_ptr, rxq.wr_ptr,
                                            rxq.count > CNT_W'(receive_queue_control.trigger));
         serial_protocol_status.busy <= (st_ff != MST_IDLE) || (slv_run_ff && !se_s2_ff);
         serial_protocol_status.addr <= addr_ff;
         block_top_status.ext_using  <= buffered && slv_run_ff && !se_s2_ff;
         if (pop_strobe) begin
            receive_queue_pop <= REG_W'(rxq.head);
         end
         receive_queue_peek <= REG_W'(rxq.head);
         buffer_memory_word <= REG_W'(bmem[buf_sw_addr]);
      end
   end
endmodule : serial_block

// ==== bench/serial_block_chk.sv ====
// serial block port assertions
`timescale 1ns/1ps
module serial_block_chk import serial_pkg::*; (
   input wire logic             mclk,
   input wire logic             rst,
   input wire top_ctrl_t        block_top_control,
   input wire proto_ctrl_t      serial_protocol_control,
   input wire qctl_t            transmit_queue_control,
   input wire logic             push_strobe,
   input wire logic             pop_strobe,
   input wire logic             spi_clk_out_en,
   input wire logic             spi_mosi_out_en,
   input wire logic             spi_select_out_en,
   input wire logic             spi_miso_out_en,
   input wire qstat_t           transmit_queue_state,
   input wire qstat_t           receive_queue_state,
   input wire logic [REG_W-1:0] receive_queue_pop,
   input wire logic [REG_W-1:0] receive_queue_peek
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire       en  = block_top_control.enable;
   wire [3:0] txc = transmit_queue_state.count;
   wire [3:0] rxc = receive_queue_state.count;
   sequence s_lone_push;
      !push_strobe ##1 push_strobe && !en && txc < 4'h8 && !transmit_queue_control.freeze
         && !transmit_queue_control.clear ##1 !push_strobe && !en;
   endsequence
   sequence s_run_start;
      $rose(en) && block_top_control.proto == PROTO_SERIAL && serial_protocol_control.master
         ##1 en [*2];
   endsequence
   property p_push;
      s_lone_push |=> txc == 4'($past(txc, 2) + 1);
   endproperty
   property p_start;
      s_run_start |=> spi_clk_out_en;
   endproperty
   property p_off;
      !en [*4] |-> !spi_clk_out_en && !spi_mosi_out_en && !spi_select_out_en && !spi_miso_out_en;
   endproperty
   property p_master_pads;
      spi_clk_out_en |-> spi_mosi_out_en && spi_select_out_en && !spi_miso_out_en;
   endproperty
   property p_slave_pads;
      spi_miso_out_en |-> !spi_mosi_out_en && !spi_clk_out_en;
   endproperty
   property p_valid;
      transmit_queue_state.valid == (txc != 4'h0) && receive_queue_state.valid == (rxc != 4'h0);
   endproperty
   property p_pop;
      pop_strobe && en && $past(en, 2) && receive_queue_state.valid && !$past(pop_strobe) |=>
         receive_queue_pop == $past(receive_queue_peek);
   endproperty
   property p_clear;
      transmit_queue_control.clear [*2] |=> txc == 4'h0;
   endproperty
   property p_reinit;
      $rose(en) && !push_strobe ##1 !push_strobe |=> txc == 4'h0 && rxc == 4'h0;
   endproperty
   a_push: assert property (p_push) else $error("push not counted");
   a_start: assert property (p_start) else $error("master pads idle");
   a_off: assert property (p_off) else $error("pads driven while off");
   a_master_pads: assert property (p_master_pads) else $error("master pads");
   a_slave_pads: assert property (p_slave_pads) else $error("slave pads");
   a_valid: assert property (p_valid) else $error("valid flag wrong");
   a_pop: assert property (p_pop) else $error("pop not head");
   a_clear: assert property (p_clear) else $error("clear left data");
   a_reinit: assert property (p_reinit) else $error("enable kept data");
endmodule : serial_block_chk
bind serial_block serial_block_chk u_chk (.*);

// ==== bench/echo_slave.sv ====
// far-side peripheral echoing data while selected
`timescale 1ns/1ps
module echo_slave (
   input wire logic sel_n,
   input wire logic mosi,
   output logic     miso
);
   logic last = 1'b0;
   always @(mosi) if (!sel_n) last = mosi;
   // a released line shows the inverse so a stale level cannot pass
   assign miso = sel_n ? ~last : mosi;
endmodule : echo_slave

// ==== bench/serial_block_bench.sv ====
// self-checking bench for the serial block
`timescale 1ns/1ps
module serial_block_bench import serial_pkg::*;;
   logic mclk = 1'b0, rst = 1'b1, push_strobe = 1'b0, pop_strobe = 1'b0, buf_sw_wr = 1'b0;
   logic spi_clk_in = 1'b0, spi_select_in = 1'b1, spi_mosi_in = 1'b0, spi_miso_in;
   logic [BUF_AW-1:0] buf_sw_addr = 8'h00;
   logic [7:0] buf_sw_wdata = 8'h00;
   logic [REG_W-1:0] transmit_queue_push = 32'h0, receive_queue_pop, receive_queue_peek;
   logic [REG_W-1:0] buffer_memory_word;
   top_ctrl_t block_top_control = '0;
   proto_ctrl_t serial_protocol_control = '0;
   fmt_t transmit_format_control = '0, receive_format_control = '0;
   qctl_t transmit_queue_control = '0, receive_queue_control = '0;
   qstat_t transmit_queue_state, receive_queue_state;
   pstat_t serial_protocol_status;
   tstat_t block_top_status;
   logic spi_clk_out, spi_clk_out_en, spi_select_out, spi_select_out_en;
   logic spi_mosi_out, spi_mosi_out_en, spi_miso_out, spi_miso_out_en;
   int n_fail = 0, n_tests = 0, cyc = 0;
   wire [3:0] pads = {spi_clk_out_en, spi_mosi_out_en, spi_select_out_en, spi_miso_out_en};
   serial_block u_dut (.*);
   echo_slave u_far (.sel_n(spi_select_out), .mosi(spi_mosi_out), .miso(spi_miso_in));
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) if (++cyc > 6000) begin
      n_fail++;
      close_out();
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic push(input logic [15:0] d, input int n);
      push_strobe = 1'b1;
      for (int i = 0; i < n; i++) begin
         transmit_queue_push = {16'h0, d + 16'(i)};
         step(1);
      end
      push_strobe = 1'b0;
      step(2);
   endtask : push
   task automatic wait_rx(input logic [3:0] n);
      for (int i = 0; i < 500 && receive_queue_state.count !== n; i++) step(1);
   endtask : wait_rx
   task automatic enable(input logic on);
      block_top_control.enable = on;
      step(4);
   endtask : enable
   initial begin
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      step(2);
      push(16'h1111, 3);
      chk(transmit_queue_state[11:1], {4'h3, 3'h0, 3'h3, 1'b1});
      transmit_queue_control.freeze = 1'b1;
      push(16'h4444, 1);
      chk(transmit_queue_state.count, 4'h3);
      transmit_queue_control = '{'0, 3'h2, 1'b1, 1'b0};
      receive_queue_control = transmit_queue_control;
      step(2);
      transmit_queue_control.clear = 1'b0;
      receive_queue_control.clear = 1'b0;
      chk(transmit_queue_state.count, 4'h0);
      serial_protocol_control.master = 1'b1;
      transmit_format_control.width = 4'hF;
      transmit_format_control.msb_first = 1'b1;
      receive_format_control = transmit_format_control;
      block_top_control.proto = PROTO_SERIAL;
      block_top_control.ovs = 4'h7;
      step(3);
      chk(pads, 4'h0);
      enable(1'b1);
      chk(pads, 4'hE);
      push(16'hA5C3, 1);
      wait_rx(4'h1);
      chk(receive_queue_peek, 32'hA5C3);
      step(3);
      chk({receive_queue_state.count, receive_queue_peek}, 36'h1_0000_A5C3);
      pop_strobe = 1'b1;
      step(1);
      chk(receive_queue_pop, 32'hA5C3);
      pop_strobe = 1'b0;
      step(2);
      chk(receive_queue_state.count, 4'h0);
      serial_protocol_control.master = 1'b0;
      step(4);
      chk(spi_clk_out_en, 1'b1);
      enable(1'b0);
      chk(pads, 4'h0);
      transmit_format_control.width = 4'h7;
      receive_format_control = transmit_format_control;
      enable(1'b1);
      // link clock runs only while selected
      spi_select_in = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         spi_mosi_in = i[0] ^ i[1] ^ i[2];
         #24 spi_clk_in = 1'b1;
         #24 spi_clk_in = 1'b0;
      end
      chk(pads, 4'h1);
      spi_mosi_in = ~spi_mosi_in;
      #10 spi_select_in = 1'b1;
      step(12);
      chk({receive_queue_state.count, receive_queue_peek}, 36'h1_0000_0096);
      enable(1'b0);
      enable(1'b1);
      chk(receive_queue_state.count, 4'h0);
      close_out();
   end
endmodule : serial_block_bench
